// file: design/ebarb_pkg.sv
// Package: constants, widths and state types for the external bus ownership arbiter
package ebarb_pkg;
    // ******************************************************************
    // Widths
    // ******************************************************************
    localparam int unsigned NUM_PEERS = 6;
    localparam int unsigned ID_W      = 3;
    localparam int unsigned ADDR_W    = 32;
    localparam int unsigned DATA_W    = 48;
    localparam int unsigned SEL_W     = 4;
    localparam int unsigned CTL_W     = 5;

    // ******************************************************************
    // Encodings and reset values
    // ******************************************************************
    localparam logic [ID_W-1:0]      ID_SINGLE    = 3'h0;
    localparam logic [ID_W-1:0]      ID_FIRST     = 3'h1;
    localparam logic [NUM_PEERS-1:0] PEERS_IDLE   = 6'h3f;
    localparam logic [ID_W-1:0]      LAST_RST     = 3'h6;
    localparam logic [ID_W-1:0]      ID_MAX       = 3'h6;
    localparam logic                 ROTATING_PRIORITY_SELECT_RST     = 1'b0;

    // Bus ownership states, Gray coded along idle -> request -> master -> host
    typedef enum logic [1:0] {
        EBARB_IDLE   = 2'b00,
        EBARB_REQ    = 2'b01,
        EBARB_MASTER = 2'b11,
        EBARB_HOST   = 2'b10
    } ebarb_own_e;
endpackage : ebarb_pkg

// file: design/ebarb_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ebarb_sync #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '1
) (
    input  wire logic         core_clk, // Core clock
    input  wire logic         sys_rst,  // Synchronous reset
    input  wire logic [W-1:0] din,      // Asynchronous pins
    output logic      [W-1:0] dout      // Synchronised copy
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // Next values of both stages
    always_comb begin
        nxt_meta = sys_rst ? RST : din;
        nxt_sync = sys_rst ? RST : meta_ff;
    end

    // Register stages; first stage only feeds the second
    always_ff @(posedge core_clk) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign dout = sync_ff;
endmodule : ebarb_sync

// file: design/ebarb_prio.sv
// Peer request priority picker: fixed or rotating
`timescale 1ns/1ps
module ebarb_prio
    import ebarb_pkg::*;
(
    input  wire logic [NUM_PEERS-1:0] req,      // Active-high requests, bit0 = ID 1
    input  wire logic                 rotate,   // High selects rotating priority
    input  wire logic [ID_W-1:0]      last_id,  // Last master ID for rotation
    output logic      [ID_W-1:0]      win_id,   // Winning ID, 0 when none
    output logic                      win_vld   // Some request present
);
    logic [ID_W-1:0] cand;
    logic            found;

    // Scan from the start point; fixed starts at ID 1, rotating after last master
    always_comb begin
        win_id  = ID_SINGLE;
        found   = 1'b0;
        cand    = ID_SINGLE;
        for (int unsigned k = 0; k < NUM_PEERS; k++) begin
            if (rotate) begin
                cand = ID_W'((32'(last_id) + k) % NUM_PEERS + 1);
            end else begin
                cand = ID_W'(k + 1);
            end
            if (!found && req[cand - ID_FIRST]) begin
                win_id = cand;
                found  = 1'b1;
            end
        end
        win_vld = found;
    end
endmodule : ebarb_prio

// file: design/ebarb_top.sv
// External bus ownership arbiter: peer and host arbitration, bus float control
`timescale 1ns/1ps
module ebarb_top
    import ebarb_pkg::*;
(
    input  wire logic                 core_clk,          // Core clock, 100 MHz
    input  wire logic                 sys_rst,           // Synchronous reset, active high
    input  wire logic [ID_W-1:0]      processor_number,  // Static ID straps
    input  wire logic                 rotating_priority_select, // High: rotating priority
    input  wire logic                 ready_active_drive_bit,   // High: ready actively driven
    input  wire logic                 suspend_bus_float_n,      // Suspend input, active low
    input  wire logic                 host_bus_request_n,       // Host request, active low
    input  wire logic                 chip_select_n,            // Host chip select, active low
    input  wire logic [NUM_PEERS-1:0] peer_bus_request_in_n,    // Peer request pins in, active low
    output logic      [NUM_PEERS-1:0] peer_bus_request_out_n,   // Peer request pins out
    output logic      [NUM_PEERS-1:0] peer_bus_request_oe,      // Peer request enables
    input  wire logic                 host_bus_grant_in_n,      // Grant pin in, active low
    output logic                      host_bus_grant_out_n,     // Grant pin out
    output logic                      host_bus_grant_oe,        // Grant pin enable
    output logic                      host_wait_ready_out,      // Ready pin level
    output logic                      host_wait_ready_oe,       // Ready pin enable
    input  wire logic                 core_priority_access_in_n, // Shared core priority in
    output logic                      core_priority_access_out_n, // Core priority out, always low
    output logic                      core_priority_access_oe,  // Core priority pull-down enable
    input  wire logic                 core_req,          // Core wants external bus, same domain
    input  wire logic                 dma_req,           // Background DMA wants bus, same domain
    input  wire logic                 host_wait,         // Internal memory not ready for host
    input  wire logic                 slave_wait,        // Internal memory not ready for master
    input  wire logic                 slave_access,      // This slave is being accessed
    output logic                      ack_out_n,         // Acknowledge pull low
    output logic                      ack_oe,            // Acknowledge drive enable
    output logic                      bus_oe,            // Enable for address, data, selects, strobes
    output logic                      bus_master,        // This processor owns the bus
    output logic                      access_go,         // External access may proceed
    output logic                      host_granted       // Host owns the bus (monitored)
);
    // ******************************************************************
    // Pin synchronisers
    // ******************************************************************
    logic [NUM_PEERS-1:0] peer_s_n;
    logic                 hbr_s_n;
    logic                 cs_s_n;
    logic                 susp_s_n;
    logic                 hbg_s_n;
    logic                 cpa_s_n;
    logic                 rotating_priority_select_s;

    // All arbitration lines sampled on the same core edge
    ebarb_sync #(.W(NUM_PEERS), .RST(PEERS_IDLE)) u_sync_peer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (peer_bus_request_in_n),
        .dout     (peer_s_n)
    );
    // Host, suspend, grant and core priority pins idle high
    ebarb_sync #(.W(CTL_W)) u_sync_ctl (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      ({host_bus_request_n, chip_select_n, suspend_bus_float_n,
                    host_bus_grant_in_n, core_priority_access_in_n}),
        .dout     ({hbr_s_n, cs_s_n, susp_s_n, hbg_s_n, cpa_s_n})
    );
    // Priority select comes out of reset as fixed priority
    ebarb_sync #(.W(1), .RST(ROTATING_PRIORITY_SELECT_RST)) u_sync_rotating_priority_select (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (rotating_priority_select),
        .dout     (rotating_priority_select_s)
    );

    // ******************************************************************
    // Straps and identity
    // ******************************************************************
    logic [ID_W-1:0] id_ff;
    logic [ID_W-1:0] nxt_id;
    logic            single;

    // ID captured while reset is held; static afterwards
    always_comb begin
        nxt_id = sys_rst ? processor_number : id_ff;
    end
    // Hold the captured ID
    always_ff @(posedge core_clk) begin
        id_ff <= nxt_id;
    end
    // Zero or an out-of-range strap runs alone
    assign single = (id_ff == ID_SINGLE) || (id_ff > ID_MAX);

    // ******************************************************************
    // Peer priority decision
    // ******************************************************************
    ebarb_own_e           st_ff;
    ebarb_own_e           nxt_st;
    logic [ID_W-1:0]      last_ff;
    logic [ID_W-1:0]      nxt_last;
    logic [NUM_PEERS-1:0] own_mask;
    logic [NUM_PEERS-1:0] req_act;
    logic [ID_W-1:0]      win_id;
    logic                 win_vld;
    logic                 want;
    logic                 cpa_block;

    // One-hot mask of own request line
    for (genvar g = 0; g < NUM_PEERS; g++) begin : g_own
        assign own_mask[g] = !single && (id_ff == ID_W'(g + 1));
    end

    // Others' active requests from pins, own from the registered drive
    assign req_act = (~peer_s_n & ~own_mask) | (own_mask & ~peer_bus_request_out_n);

    ebarb_prio u_prio (
        .req     (req_act),
        .rotate  (rotating_priority_select_s),
        .last_id (last_ff),
        .win_id  (win_id),
        .win_vld (win_vld)
    );

    // Core priority: any asserted line holds off DMA-only requests
    assign cpa_block = !cpa_s_n && !core_req;
    assign want      = core_req || (dma_req && !cpa_block);

    // ******************************************************************
    // Peer tenure
    // ******************************************************************
    logic peer_hold_ff;
    logic nxt_peer_hold;
    logic last_req;
    logic peer_busy;

    // Line of the last winner still low
    assign last_req  = req_act[last_ff - ID_FIRST];
    // A winning peer keeps the bus while it requests, so two never drive it
    assign peer_busy = peer_hold_ff && last_req;

    // ******************************************************************
    // Ownership state machine
    // ******************************************************************
    // Host beats peers; master yields and grants while host holds request
    always_comb begin
        nxt_st        = st_ff;
        nxt_last      = last_ff;
        // Tenure ends once the winner's line goes high
        nxt_peer_hold = peer_hold_ff && last_req;
        unique case (st_ff)
            EBARB_IDLE: begin
                if (!hbr_s_n) begin
                    nxt_st = EBARB_HOST;
                end else if (want) begin
                    nxt_st = single ? EBARB_MASTER : EBARB_REQ;
                end
            end
            EBARB_REQ: begin
                if (!hbr_s_n || !hbg_s_n) begin
                    nxt_st = EBARB_HOST;
                end else if (!want) begin
                    nxt_st = EBARB_IDLE;
                end else if (peer_busy) begin
                    nxt_st = EBARB_REQ;
                end else if (win_vld && win_id == id_ff) begin
                    nxt_st   = EBARB_MASTER;
                    nxt_last = id_ff;
                end else if (win_vld) begin
                    nxt_last      = win_id;
                    nxt_peer_hold = 1'b1;
                end
            end
            EBARB_MASTER: begin
                if (!hbr_s_n) begin
                    nxt_st = EBARB_HOST;
                end else if (!want) begin
                    nxt_st = EBARB_IDLE;
                end
            end
            EBARB_HOST: begin
                if (hbr_s_n && hbg_s_n) begin
                    nxt_st = EBARB_IDLE;
                end
            end
        endcase
        if (sys_rst) begin
            nxt_st        = EBARB_IDLE;
            nxt_last      = LAST_RST;
            nxt_peer_hold = 1'b0;
        end
    end
    // Register ownership, rotation point and tenure
    always_ff @(posedge core_clk) begin
        st_ff        <= nxt_st;
        last_ff      <= nxt_last;
        peer_hold_ff <= nxt_peer_hold;
    end

    // ******************************************************************
    // Pin drive registers
    // ******************************************************************
    logic                 was_master_ff;
    logic                 nxt_was_master;
    logic [NUM_PEERS-1:0] nxt_br_n;
    logic [NUM_PEERS-1:0] nxt_br_oe;
    logic                 nxt_hbg_n;
    logic                 nxt_hbg_oe;
    logic                 nxt_rdy;
    logic                 nxt_rdy_oe;
    logic                 nxt_cpa_oe;
    logic                 nxt_ack_oe;
    logic                 nxt_bus_oe;
    logic                 nxt_master;
    logic                 nxt_go;
    logic                 nxt_hgr;
    logic                 own_bus;
    logic                 host_sel;

    assign own_bus  = (nxt_st == EBARB_MASTER);
    assign host_sel = !cs_s_n && !hbr_s_n;

    // Compute next pin drives from the decided ownership
    always_comb begin
        // Grant driven only by the master that handed over the bus
        nxt_was_master = (st_ff == EBARB_MASTER) ? 1'b1 :
                         (st_ff == EBARB_HOST) ? was_master_ff : 1'b0;
        nxt_hbg_oe = (nxt_st == EBARB_HOST) && nxt_was_master;
        nxt_hbg_n  = !(nxt_st == EBARB_HOST && !hbr_s_n);
        nxt_br_oe  = own_mask;
        nxt_br_n   = ~(own_mask & {NUM_PEERS{nxt_st == EBARB_REQ || own_bus}});
        nxt_rdy    = !host_wait;
        // Open drain drives only low; active mode drives both levels
        nxt_rdy_oe = host_sel && (ready_active_drive_bit || host_wait);
        nxt_cpa_oe = core_req && !own_bus && !single;
        nxt_ack_oe = slave_access && slave_wait;
        nxt_bus_oe = own_bus && susp_s_n;
        nxt_master = own_bus;
        nxt_go     = own_bus && susp_s_n && (core_req || dma_req);
        nxt_hgr    = (nxt_st == EBARB_HOST);
        if (sys_rst) begin
            nxt_was_master = 1'b0;
            nxt_hbg_oe     = 1'b0;
            nxt_hbg_n      = 1'b1;
            nxt_br_oe      = '0;
            nxt_br_n       = PEERS_IDLE;
            nxt_rdy        = 1'b1;
            nxt_rdy_oe     = 1'b0;
            nxt_cpa_oe     = 1'b0;
            nxt_ack_oe     = 1'b0;
            nxt_bus_oe     = 1'b0;
            nxt_master     = 1'b0;
            nxt_go         = 1'b0;
            nxt_hgr        = 1'b0;
        end
    end

    // Register every pin drive except the open-drain levels
    always_ff @(posedge core_clk) begin
        was_master_ff           <= nxt_was_master;
        host_bus_grant_oe       <= nxt_hbg_oe;
        host_bus_grant_out_n    <= nxt_hbg_n;
        peer_bus_request_oe     <= nxt_br_oe;
        peer_bus_request_out_n  <= nxt_br_n;
        host_wait_ready_out     <= nxt_rdy;
        host_wait_ready_oe      <= nxt_rdy_oe;
        core_priority_access_oe <= nxt_cpa_oe;
        ack_oe                  <= nxt_ack_oe;
        bus_oe                  <= nxt_bus_oe;
        bus_master              <= nxt_master;
        access_go               <= nxt_go;
        host_granted            <= nxt_hgr;
    end

    // ******************************************************************
    // Open-drain levels
    // ******************************************************************
    // Open-drain lines only ever pull low
    always_ff @(posedge core_clk) begin
        core_priority_access_out_n <= 1'b0;
        ack_out_n                  <= 1'b0;
    end
endmodule : ebarb_top

// file: sim/ebarb_assertions.sv
// Concurrent checks on the bus arbiter ports
`timescale 1ns/1ps
module ebarb_assertions
    import ebarb_pkg::*;
(
    input wire logic                 core_clk,               // Clock
    input wire logic                 sys_rst,                // Reset
    input wire logic [ID_W-1:0]      processor_number,       // ID straps
    input wire logic                 ready_active_drive_bit, // Ready mode
    input wire logic                 suspend_bus_float_n,    // Suspend pin
    input wire logic                 host_bus_request_n,     // Host request
    input wire logic                 chip_select_n,          // Chip select
    input wire logic [NUM_PEERS-1:0] peer_bus_request_oe,    // Request enables
    input wire logic                 host_bus_grant_out_n,   // Grant level
    input wire logic                 host_bus_grant_oe,      // Grant enable
    input wire logic                 host_wait_ready_out,    // Ready level
    input wire logic                 host_wait_ready_oe,     // Ready enable
    input wire logic                 bus_oe,                 // Bus enable
    input wire logic                 bus_master,             // Owns bus
    input wire logic                 access_go,              // Access may run
    input wire logic                 host_granted            // Host owns bus
);
    // ********
    // Checks
    // ********
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Pin held low long enough to pass the synchroniser
    sequence s_susp_held;
        !suspend_bus_float_n [*3];
    endsequence
    sequence s_host_held;
        !host_bus_request_n [*4];
    endsequence

    susp_float_a: assert property (s_susp_held |=> !bus_oe && !access_go)
        else $error("bus still driven under suspend");
    bus_own_a: assert property (bus_oe |-> bus_master && !host_granted)
        else $error("bus driven without ownership");
    host_take_a: assert property (s_host_held |-> ##[0:2] (host_granted && !bus_oe))
        else $error("host request not served");
    grant_hold_a: assert property ((host_bus_grant_oe && !host_bus_grant_out_n && !host_bus_request_n)
        |=> (host_bus_grant_oe && !host_bus_grant_out_n))
        else $error("grant dropped while host requests");
    grant_owner_a: assert property (host_bus_grant_oe |-> host_granted)
        else $error("grant driven outside host tenure");
    ready_sel_a: assert property (chip_select_n [*3] |=> !host_wait_ready_oe)
        else $error("ready driven while not selected");
    ready_od_a: assert property ((!ready_active_drive_bit && !$past(ready_active_drive_bit)
        && host_wait_ready_oe) |-> !host_wait_ready_out)
        else $error("ready driven high in open drain mode");
    own_line_a: assert property ((peer_bus_request_oe != 6'h00)
        |-> (peer_bus_request_oe == (6'h01 << (processor_number - 3'h1))))
        else $error("wrong request line driven");
endmodule : ebarb_assertions

bind ebarb_top ebarb_assertions i_chk (.*);

// file: sim/ebarb_bus_model.sv
// Board and peer processors around one arbiter
`timescale 1ns/1ps
module ebarb_bus_model
    import ebarb_pkg::*;
(
    input  wire logic                 core_clk,                   // Clock
    input  wire logic                 host_bus_request_n,         // Host request
    input  wire logic [NUM_PEERS-1:0] other_req_n,                // Other peers requesting
    input  wire logic                 other_cpa,                  // Other slave wants core priority
    input  wire logic [NUM_PEERS-1:0] peer_bus_request_out_n,     // Arbiter request levels
    input  wire logic [NUM_PEERS-1:0] peer_bus_request_oe,        // Arbiter request enables
    input  wire logic                 host_bus_grant_out_n,       // Arbiter grant level
    input  wire logic                 host_bus_grant_oe,          // Arbiter grant enable
    input  wire logic                 core_priority_access_out_n, // Arbiter core priority level
    input  wire logic                 core_priority_access_oe,    // Arbiter core priority enable
    output logic      [NUM_PEERS-1:0] peer_bus_request_in_n,      // Resolved request lines
    output logic                      host_bus_grant_in_n,        // Resolved grant line
    output logic                      core_priority_access_in_n   // Resolved core priority line
);
    logic peer_grant_ff;

    // Own line from the arbiter, other lines from peers or tied high
    always_comb begin
        for (int i = 0; i < NUM_PEERS; i++) begin
            peer_bus_request_in_n[i] = peer_bus_request_oe[i] ? peer_bus_request_out_n[i] : other_req_n[i];
        end
    end

    // A peer master yields to the host one cycle after the request
    always_ff @(posedge core_clk) begin
        peer_grant_ff <= !host_bus_request_n && !(&other_req_n);
    end
    assign host_bus_grant_in_n = host_bus_grant_oe ? host_bus_grant_out_n : !peer_grant_ff;

    // Wired core priority line with pull-up
    assign core_priority_access_in_n = !((core_priority_access_oe && !core_priority_access_out_n) || other_cpa);
endmodule : ebarb_bus_model

// file: sim/ebarb_top_tb.sv
// Self-checking bench for the bus arbiter
`timescale 1ns/1ps
module ebarb_top_tb
    import ebarb_pkg::*;
;
    logic                 core_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic [ID_W-1:0]      processor_number = 3'h1;
    logic                 rotating_priority_select = 1'b0;
    logic                 ready_active_drive_bit = 1'b0;
    logic                 suspend_bus_float_n = 1'b1;
    logic                 host_bus_request_n = 1'b1;
    logic                 chip_select_n = 1'b1;
    logic                 core_req = 1'b0;
    logic                 dma_req = 1'b0;
    logic                 host_wait = 1'b0;
    logic                 slave_wait = 1'b0;
    logic                 slave_access = 1'b0;
    logic                 other_cpa = 1'b0;
    logic [NUM_PEERS-1:0] other_req_n = 6'h3f;
    logic [NUM_PEERS-1:0] peer_bus_request_in_n, peer_bus_request_out_n, peer_bus_request_oe;
    logic                 host_bus_grant_in_n, host_bus_grant_out_n, host_bus_grant_oe;
    logic                 host_wait_ready_out, host_wait_ready_oe, ack_out_n, ack_oe;
    logic                 core_priority_access_in_n, core_priority_access_out_n, core_priority_access_oe;
    logic                 bus_oe, bus_master, access_go, host_granted;
    int                   err_count = 0;
    int                   tests_run = 0;
    int                   cycle_cnt = 0;

    // Clock and instances
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    ebarb_top i_dut (.*);
    ebarb_bus_model i_bus (.*);

    // ********
    // Helpers
    // ********
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic look(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : look

    task automatic restart(input logic [2:0] id, input logic rot);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        processor_number <= id;
        rotating_priority_select <= rot;
        core_req <= 1'b0;
        dma_req <= 1'b0;
        other_cpa <= 1'b0;
        other_req_n <= 6'h3f;
        host_bus_request_n <= 1'b1;
        chip_select_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask : restart

    // ********
    // Scenarios
    // ********
    task automatic t_own_line();
        for (int i = 0; i < 7; i++) begin
            restart(i[2:0], 1'b0);
            core_req <= 1'b1;
            look(8);
            check(bus_master, 1'b1);
            check(peer_bus_request_oe, (i == 0) ? 6'h00 : 6'h01 << (i - 1));
        end
    endtask : t_own_line

    task automatic t_fixed();
        restart(3'h2, 1'b0);
        other_req_n <= 6'h3e;
        look(3);
        @(posedge core_clk);
        core_req <= 1'b1;
        host_bus_request_n <= 1'b0;
        look(8);
        check(bus_master, 1'b0);
        check(peer_bus_request_out_n[1], 1'b1);
        check(host_bus_grant_oe, 1'b0);
        @(posedge core_clk);
        host_bus_request_n <= 1'b1;
        other_req_n <= 6'h3f;
        look(12);
        check(bus_master, 1'b1);
    endtask : t_fixed

    task automatic t_rotate();
        restart(3'h1, 1'b1);
        core_req <= 1'b1;
        look(8);
        check(bus_master, 1'b1);
        @(posedge core_clk);
        other_req_n <= 6'h3d;
        core_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        core_req <= 1'b1;
        look(8);
        check(bus_master, 1'b0);
        @(posedge core_clk);
        other_req_n <= 6'h3f;
        look(8);
        check(bus_master, 1'b1);
    endtask : t_rotate

    task automatic t_host();
        restart(3'h1, 1'b0);
        core_req <= 1'b1;
        look(8);
        @(posedge core_clk);
        other_req_n <= 6'h3d;
        host_bus_request_n <= 1'b0;
        look(6);
        check(host_granted, 1'b1);
        check({host_bus_grant_oe, host_bus_grant_out_n, bus_oe}, 3'b100);
        look(10);
        check({host_bus_grant_oe, host_bus_grant_out_n}, 2'b10);
        @(posedge core_clk);
        host_bus_request_n <= 1'b1;
        other_req_n <= 6'h3f;
        look(12);
        check({host_bus_grant_oe, host_granted, bus_oe}, 3'b001);
    endtask : t_host

    task automatic t_suspend();
        restart(3'h3, 1'b0);
        core_req <= 1'b1;
        look(8);
        @(posedge core_clk);
        suspend_bus_float_n <= 1'b0;
        look(4);
        check({bus_oe, access_go, bus_master}, 3'b001);
        look(10);
        check(access_go, 1'b0);
        @(posedge core_clk);
        suspend_bus_float_n <= 1'b1;
        look(4);
        check({bus_oe, access_go}, 2'b11);
    endtask : t_suspend

    task automatic t_ready();
        restart(3'h0, 1'b0);
        chip_select_n <= 1'b0;
        host_bus_request_n <= 1'b0;
        host_wait <= 1'b1;
        ready_active_drive_bit <= 1'b0;
        look(5);
        check({host_wait_ready_oe, host_wait_ready_out}, 2'b10);
        @(posedge core_clk);
        host_wait <= 1'b0;
        look(3);
        check(host_wait_ready_oe, 1'b0);
        @(posedge core_clk);
        ready_active_drive_bit <= 1'b1;
        look(3);
        check({host_wait_ready_oe, host_wait_ready_out}, 2'b11);
        @(posedge core_clk);
        chip_select_n <= 1'b1;
        look(4);
        check(host_wait_ready_oe, 1'b0);
    endtask : t_ready

    task automatic t_core_prio();
        restart(3'h2, 1'b0);
        other_req_n <= 6'h3e;
        look(3);
        @(posedge core_clk);
        core_req <= 1'b1;
        slave_access <= 1'b1;
        slave_wait <= 1'b1;
        look(5);
        check({core_priority_access_oe, core_priority_access_out_n}, 2'b10);
        check({ack_oe, ack_out_n}, 2'b10);
        @(posedge core_clk);
        slave_wait <= 1'b0;
        slave_access <= 1'b0;
        core_req <= 1'b0;
        other_cpa <= 1'b1;
        dma_req <= 1'b1;
        other_req_n <= 6'h3f;
        look(8);
        check({ack_oe, bus_master, core_priority_access_oe}, 3'b000);
        @(posedge core_clk);
        other_cpa <= 1'b0;
        look(8);
        check(bus_master, 1'b1);
    endtask : t_core_prio

    // Closing report
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // Hang guard
    always @(posedge core_clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 2000) begin
            err_count++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        t_own_line();
        t_fixed();
        t_rotate();
        t_host();
        t_suspend();
        t_ready();
        t_core_prio();
        end_of_test();
    end
endmodule : ebarb_top_tb
